// *** verilog/sli_pkg.sv ***
// constants for the status lamp and crash code indicator
package sli_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  SLI_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  SLI_CODE_OFS     = 8'h04;
    localparam logic [7:0]  SLI_STATE_OFS    = 8'h08;
    localparam logic [7:0]  SLI_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0]  SLI_IRQ_MASK_OFS = 8'h10;

    // control register fields (write-only actions plus one held bit)
    localparam int          SLI_CTRL_KERNEL  = 0;
    localparam int          SLI_CTRL_RUN     = 1;
    localparam int          SLI_CTRL_FAULT   = 2;

    // interrupt status fields
    localparam int          SLI_IRQ_PROG     = 0;
    localparam int          SLI_IRQ_OVR1     = 1;
    localparam int          SLI_IRQ_OVR2     = 2;
    localparam int          SLI_IRQ_KERNEL   = 3;
    localparam int          SLI_IRQ_W        = 4;

    // reset values
    localparam logic [15:0] SLI_CODE_RST     = 16'h0000;
    localparam logic [3:0]  SLI_MASK_RST     = 4'h0;

    // crash codes
    localparam logic [15:0] SLI_CODE_REQ     = 16'h0000;
    localparam logic [15:0] SLI_CODE_IRQ     = 16'h6631;
    localparam logic [15:0] SLI_CODE_RAMADR  = 16'h6503;
    localparam logic [15:0] SLI_CODE_RAMDAT  = 16'h6402;
    localparam logic [15:0] SLI_CODE_PROM_NX = 16'h6300;
    localparam logic [15:0] SLI_CODE_PROM    = 16'h6301;
    localparam logic [15:0] SLI_CODE_FLASHM  = 16'h630a;
    localparam logic [15:0] SLI_CODE_WDOG    = 16'h630b;
    localparam logic [15:0] SLI_CODE_KFIRST  = 16'h8000;
    localparam logic [15:0] SLI_CODE_KLAST   = 16'h8003;

    // timing: clock rate and lamp timing
    localparam longint      SLI_CLK_HZ       = 250_000_000;
    localparam longint      SLI_BLINK_NS     = 1_000_000_000;
    localparam longint      SLI_PAUSE_NS     = 2_000_000_000;
    localparam longint      SLI_HALF_CYC     = (SLI_BLINK_NS / 2) * SLI_CLK_HZ / 1_000_000_000;
    localparam longint      SLI_PAUSE_CYC    = (SLI_PAUSE_NS * SLI_CLK_HZ + 999_999_999) / 1_000_000_000;

    // fixed programming port setup
    localparam longint      SLI_PROG_BAUD    = 9600;
    localparam logic [15:0] SLI_PROG_BAUD_DIV = 16'((SLI_CLK_HZ + SLI_PROG_BAUD / 2) / SLI_PROG_BAUD);
    localparam logic [3:0]  SLI_PROG_DBITS   = 4'h8;
    localparam logic [1:0]  SLI_PROG_SBITS   = 2'h1;

    typedef enum logic [1:0] {SLI_RUN, SLI_PROG, SLI_KERNEL} sli_mode_t;
    typedef enum logic [1:0] {SLI_BL_IDLE, SLI_BL_ON, SLI_BL_OFF, SLI_BL_PAUSE} sli_blink_t;

endpackage

// *** verilog/sli_indicator.sv ***
// status lamp, port error lamp and programming mode controller
// ************************************************************
// Functional notes
// - programming mode: status steady, other lamps dark
// - port one overrun lights error lamp one
// - port two overrun lights error lamp two
// - kernel mode shows code; code 0000 steady
// - one blink per second; 6631 gives four
// - 6503 five blinks, 6402 six blinks
// - 6300, 6301, 630a, 630b give seven blinks
// - 8000 through 8003 give eight blinks
// - programming only after front push button
// - programming port fixed 9600, 8N1
// - programming port echoes and uses xon/xoff
// - reset push button resets whole module
// ************************************************************
`timescale 1ns/100ps
`default_nettype none

module sli_indicator
    import sli_pkg::*;
#(
    parameter longint HALF_CYC  = SLI_HALF_CYC,
    parameter longint PAUSE_CYC = SLI_PAUSE_CYC
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        reset_btn_i,
    // front panel and port events
    input  wire logic        prog_btn_i,
    input  wire logic        ovr1_i,
    input  wire logic        ovr2_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output var  logic [31:0] rdata_o,
    // lamps
    output var  logic        led_fault_o,
    output var  logic        led_status_o,
    output var  logic        led_err1_o,
    output var  logic        led_err2_o,
    // programming port setup
    output var  logic        prog_en_o,
    output var  logic [15:0] prog_baud_div_o,
    output var  logic [3:0]  prog_data_bits_o,
    output var  logic [1:0]  prog_stop_bits_o,
    output var  logic        prog_parity_en_o,
    output var  logic        prog_echo_o,
    output var  logic        prog_xonxoff_o,
    // interrupt
    output var  logic        irq_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    // unknown nonzero codes are shown as the general kernel fault group
    function automatic logic [3:0] code_blinks(input logic [15:0] code);
        logic [3:0] n;
        n = 4'h8;
        if (code == SLI_CODE_REQ)
            n = 4'h0;
        else if (code == SLI_CODE_IRQ)
            n = 4'h4;
        else if (code == SLI_CODE_RAMADR)
            n = 4'h5;
        else if (code == SLI_CODE_RAMDAT)
            n = 4'h6;
        else if (code == SLI_CODE_PROM_NX || code == SLI_CODE_PROM
              || code == SLI_CODE_FLASHM || code == SLI_CODE_WDOG)
            n = 4'h7;
        else if (code >= SLI_CODE_KFIRST && code <= SLI_CODE_KLAST)
            n = 4'h8;
        return n;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    localparam logic [31:0] HALF_W  = 32'(HALF_CYC - 1);
    localparam logic [31:0] PAUSE_W = 32'(PAUSE_CYC - 1);

    // ************************************************************
    // reset and front panel
    // ************************************************************
    logic            rst;
    logic            btn_q;
    logic            btn_rise;
    sli_mode_t       mode;
    sli_mode_t       next_mode;
    logic [15:0]     code;
    logic            kfault;
    logic            err1;
    logic            err2;
    logic [3:0]      irq_stat;
    logic [3:0]      irq_mask;
    logic [3:0]      irq_set;
    logic            wr_ctrl;
    sli_blink_t      bl_state;
    logic [31:0]     bl_cnt;
    logic [3:0]      bl_left;
    logic [3:0]      blinks;

    assign rst      = !rstn_i || reset_btn_i;
    assign btn_rise = prog_btn_i && !btn_q;
    assign wr_ctrl  = we_i && hit(addr_i, SLI_CTRL_OFS);
    assign blinks   = code_blinks(code);

    always_ff @(posedge clk_i)
    begin
        if (rst)
            btn_q <= 1'b0;
        else
            btn_q <= prog_btn_i;
    end

    // ************************************************************
    // operating mode
    // ************************************************************
    // a kernel request outranks a button press in the same cycle
    always_comb
    begin
        next_mode = mode;
        if (wr_ctrl && wdata_i[SLI_CTRL_KERNEL])
            next_mode = SLI_KERNEL;
        else if (wr_ctrl && wdata_i[SLI_CTRL_RUN])
            next_mode = SLI_RUN;
        else if (btn_rise && mode == SLI_RUN)
            next_mode = SLI_PROG;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst)
            mode <= SLI_RUN;
        else
            mode <= next_mode;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            code   <= SLI_CODE_RST;
            kfault <= 1'b0;
        end
        else
        begin
            if (we_i && hit(addr_i, SLI_CODE_OFS))
                code <= wdata_i[15:0];
            if (wr_ctrl)
                kfault <= wdata_i[SLI_CTRL_FAULT];
        end
    end

    // error flags live only in the running mode
    always_ff @(posedge clk_i)
    begin
        if (rst || mode != SLI_RUN || next_mode != SLI_RUN)
        begin
            err1 <= 1'b0;
            err2 <= 1'b0;
        end
        else
        begin
            if (ovr1_i)
                err1 <= 1'b1;
            if (ovr2_i)
                err2 <= 1'b1;
        end
    end

    always_comb
    begin
        irq_set                 = 4'h0;
        irq_set[SLI_IRQ_PROG]   = next_mode == SLI_PROG && mode != SLI_PROG;
        irq_set[SLI_IRQ_OVR1]   = ovr1_i && mode == SLI_RUN;
        irq_set[SLI_IRQ_OVR2]   = ovr2_i && mode == SLI_RUN;
        irq_set[SLI_IRQ_KERNEL] = next_mode == SLI_KERNEL && mode != SLI_KERNEL;
    end

    // an event in the clearing cycle survives the clear
    always_ff @(posedge clk_i)
    begin
        if (rst)
            irq_stat <= 4'h0;
        else if (we_i && hit(addr_i, SLI_IRQ_STAT_OFS))
            irq_stat <= (irq_stat & ~wdata_i[SLI_IRQ_W-1:0]) | irq_set;
        else
            irq_stat <= irq_stat | irq_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst)
            irq_mask <= SLI_MASK_RST;
        else if (we_i && hit(addr_i, SLI_IRQ_MASK_OFS))
            irq_mask <= wdata_i[SLI_IRQ_W-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst)
            irq_o <= 1'b0;
        else
            irq_o <= |(next_irq_stat() & irq_mask);
    end

    function automatic logic [3:0] next_irq_stat();
        if (we_i && hit(addr_i, SLI_IRQ_STAT_OFS))
            return (irq_stat & ~wdata_i[SLI_IRQ_W-1:0]) | irq_set;
        return irq_stat | irq_set;
    endfunction

    // unmapped reads and idle cycles return zero
    always_ff @(posedge clk_i)
    begin
        if (rst || !re_i)
            rdata_o <= 32'h0;
        else
        begin
            unique case (addr_i)
                SLI_CTRL_OFS:     rdata_o <= {29'h0, kfault, 2'h0};
                SLI_CODE_OFS:     rdata_o <= {16'h0, code};
                SLI_STATE_OFS:    rdata_o <= {24'h0, blinks, err2, err1, mode};
                SLI_IRQ_STAT_OFS: rdata_o <= {28'h0, irq_stat};
                SLI_IRQ_MASK_OFS: rdata_o <= {28'h0, irq_mask};
                default:          rdata_o <= 32'h0;
            endcase
        end
    end

    // ************************************************************
    // blink sequencer
    // ************************************************************
    // the counter is 32 bits so the full two second pause fits
    always_ff @(posedge clk_i)
    begin
        if (rst || mode != SLI_KERNEL || blinks == 4'h0)
        begin
            bl_state <= SLI_BL_IDLE;
            bl_cnt   <= 32'h0;
            bl_left  <= 4'h0;
        end
        else
        begin
            unique case (bl_state)
                SLI_BL_IDLE, SLI_BL_PAUSE:
                    if (bl_state == SLI_BL_IDLE || bl_cnt == PAUSE_W)
                    begin
                        bl_state <= SLI_BL_ON;
                        bl_cnt   <= 32'h0;
                        bl_left  <= blinks;
                    end
                    else
                        bl_cnt <= bl_cnt + 32'h1;
                SLI_BL_ON:
                    if (bl_cnt == HALF_W)
                    begin
                        bl_state <= SLI_BL_OFF;
                        bl_cnt   <= 32'h0;
                        bl_left  <= bl_left - 4'h1;
                    end
                    else
                        bl_cnt <= bl_cnt + 32'h1;
                SLI_BL_OFF:
                    if (bl_cnt == HALF_W)
                    begin
                        bl_state <= (bl_left == 4'h0) ? SLI_BL_PAUSE : SLI_BL_ON;
                        bl_cnt   <= 32'h0;
                    end
                    else
                        bl_cnt <= bl_cnt + 32'h1;
            endcase
        end
    end

    // ************************************************************
    // lamps
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            led_fault_o  <= 1'b0;
            led_status_o <= 1'b0;
            led_err1_o   <= 1'b0;
            led_err2_o   <= 1'b0;
        end
        else
        begin
            unique case (mode)
                SLI_PROG:
                begin
                    led_fault_o  <= 1'b0;
                    led_status_o <= 1'b1;
                    led_err1_o   <= 1'b0;
                    led_err2_o   <= 1'b0;
                end
                SLI_KERNEL:
                begin
                    led_fault_o  <= kfault;
                    led_status_o <= blinks == 4'h0 || bl_state == SLI_BL_ON;
                    led_err1_o   <= 1'b0;
                    led_err2_o   <= 1'b0;
                end
                default:
                begin
                    led_fault_o  <= 1'b0;
                    led_status_o <= 1'b0;
                    led_err1_o   <= err1;
                    led_err2_o   <= err2;
                end
            endcase
        end
    end

    // ************************************************************
    // programming port setup
    // ************************************************************
    // the fixed setup is presented only while programming; prog_en_o and
    // every other setup output are driven to zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst || mode != SLI_PROG)
        begin
            prog_en_o        <= 1'b0;
            prog_baud_div_o  <= 16'h0;
            prog_data_bits_o <= 4'h0;
            prog_stop_bits_o <= 2'h0;
            prog_parity_en_o <= 1'b0;
            prog_echo_o      <= 1'b0;
            prog_xonxoff_o   <= 1'b0;
        end
        else
        begin
            prog_en_o        <= 1'b1;
            prog_baud_div_o  <= SLI_PROG_BAUD_DIV;
            prog_data_bits_o <= SLI_PROG_DBITS;
            prog_stop_bits_o <= SLI_PROG_SBITS;
            prog_parity_en_o <= 1'b0;
            prog_echo_o      <= 1'b1;
            prog_xonxoff_o   <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// *** tb/sli_indicator_chk.sv ***
// assertions on the ports of the status lamp indicator
`timescale 1ns/100ps
`default_nettype none
module sli_indicator_chk
#(
    parameter longint HALF_CYC  = 5,
    parameter longint PAUSE_CYC = 12
)
(
    // clock, reset and inputs
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        reset_btn_i,
    input  wire logic        prog_btn_i,
    input  wire logic        we_i,
    // lamps and port setup
    input  wire logic        led_fault_o,
    input  wire logic        led_status_o,
    input  wire logic        led_err1_o,
    input  wire logic        led_err2_o,
    input  wire logic        prog_en_o,
    input  wire logic [15:0] prog_baud_div_o,
    input  wire logic [3:0]  prog_data_bits_o,
    input  wire logic [1:0]  prog_stop_bits_o,
    input  wire logic        prog_parity_en_o,
    input  wire logic        prog_echo_o,
    input  wire logic        prog_xonxoff_o
);
    // ************************************************************
    // helper counters
    // ************************************************************
    logic        rst;
    logic [5:0]  act_q;
    logic [31:0] on_cnt;
    logic [31:0] off_cnt;
    assign rst = !rstn_i || reset_btn_i;
    // recent writes, button presses or a reset may legally cut a blink short
    always_ff @(posedge clk_i)
    begin
        act_q   <= rst ? 6'h3f : {act_q[4:0], we_i | prog_btn_i};
        on_cnt  <= (rst || !led_status_o) ? 32'h0 : on_cnt + 32'h1;
        off_cnt <= (rst || led_status_o) ? 32'h0 : off_cnt + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst);
    a_prog_lamps: assert property (prog_en_o |-> led_status_o && !led_fault_o && !led_err1_o && !led_err2_o)
        else $error("lamps wrong in programming mode");
    a_prog_port_setup: assert property (prog_en_o |-> prog_baud_div_o == 16'h65ba && prog_data_bits_o == 4'h8
        && prog_stop_bits_o == 2'h1 && !prog_parity_en_o && prog_echo_o && prog_xonxoff_o)
        else $error("programming port setup wrong");
    a_err_one_dark: assert property (led_err1_o |-> !led_status_o && !led_fault_o)
        else $error("port one lamp lit with other lamps");
    a_err_two_dark: assert property (led_err2_o |-> !led_status_o && !led_fault_o)
        else $error("port two lamp lit with other lamps");
    a_err_lamp_hold: assert property (led_err1_o && act_q == 6'h00 && !we_i && !prog_btn_i |=> led_err1_o)
        else $error("port one lamp dropped");
    a_blink_on_time: assert property ($fell(led_status_o) && act_q == 6'h00 |-> on_cnt == HALF_CYC)
        else $error("blink on time wrong");
    a_blink_gap_time: assert property ($rose(led_status_o) && act_q == 6'h00 |->
        off_cnt == HALF_CYC || off_cnt == HALF_CYC + PAUSE_CYC)
        else $error("blink gap or pause wrong");
    a_button_reset: assert property (disable iff (!rstn_i) reset_btn_i |=>
        !led_status_o && !led_fault_o && !led_err1_o && !led_err2_o && !prog_en_o)
        else $error("reset button left lamps lit");
    c_prog_entered: cover property ($rose(prog_en_o));
    c_err_lit: cover property ($rose(led_err1_o));
    c_blink_done: cover property ($fell(led_status_o) && act_q == 6'h00);
endmodule
bind sli_indicator sli_indicator_chk #(.HALF_CYC(HALF_CYC), .PAUSE_CYC(PAUSE_CYC)) chk_u
(
    .clk_i, .rstn_i, .reset_btn_i, .prog_btn_i, .we_i, .led_fault_o, .led_status_o, .led_err1_o,
    .led_err2_o, .prog_en_o, .prog_baud_div_o, .prog_data_bits_o, .prog_stop_bits_o, .prog_parity_en_o,
    .prog_echo_o, .prog_xonxoff_o
);
`default_nettype wire

// *** tb/sli_term_model.sv ***
// programming terminal model: accepts the link only on its own settings
`timescale 1ns/100ps
`default_nettype none
module sli_term_model
#(
    parameter longint CLK_HZ = 250_000_000,
    parameter longint BAUD   = 9600
)
(
    // port setup offered by the module
    input  wire logic        prog_en_i,
    input  wire logic [15:0] baud_div_i,
    input  wire logic [3:0]  data_bits_i,
    input  wire logic [1:0]  stop_bits_i,
    input  wire logic        parity_en_i,
    input  wire logic        echo_i,
    input  wire logic        xonxoff_i,
    // terminal verdict
    output var  logic        link_ok_o
);
    // no dialogue is attempted outside programming mode
    assign link_ok_o = prog_en_i
        && baud_div_i == 16'((CLK_HZ + BAUD / 2) / BAUD) && data_bits_i == 4'h8
        && stop_bits_i == 2'h1 && !parity_en_i && echo_i && xonxoff_i;
endmodule
`default_nettype wire

// *** tb/test_sli_indicator.sv ***
// self-checking bench for the status lamp indicator
`timescale 1ns/100ps
`default_nettype none
module test_sli_indicator
    import sli_pkg::*;
;
    // short lamp timing keeps the run small
    localparam int HALF  = 5;
    localparam int PAUSE = 12;
    logic        clk_i, rstn_i, reset_btn_i, prog_btn_i, ovr1_i, ovr2_i, we_i, re_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, v;
    logic        led_fault_o, led_status_o, led_err1_o, led_err2_o, prog_en_o, link_ok;
    logic [15:0] prog_baud_div_o;
    logic [3:0]  prog_data_bits_o;
    logic [1:0]  prog_stop_bits_o;
    logic        prog_parity_en_o, prog_echo_o, prog_xonxoff_o, irq_o;
    int          bad_count = 0;
    int          total_checks = 0;
    logic [15:0] codes [11] = '{16'h6631, 16'h6503, 16'h6402, 16'h6300, 16'h6301, 16'h630a,
                                16'h630b, 16'h8000, 16'h8001, 16'h8002, 16'h8003};
    int          nblk [11] = '{4, 5, 6, 7, 7, 7, 7, 8, 8, 8, 8};
    sli_indicator #(.HALF_CYC(HALF), .PAUSE_CYC(PAUSE)) dut_u
    (
        .clk_i, .rstn_i, .reset_btn_i, .prog_btn_i, .ovr1_i, .ovr2_i, .addr_i, .wdata_i, .we_i, .re_i,
        .rdata_o, .led_fault_o, .led_status_o, .led_err1_o, .led_err2_o, .prog_en_o, .prog_baud_div_o,
        .prog_data_bits_o, .prog_stop_bits_o, .prog_parity_en_o, .prog_echo_o, .prog_xonxoff_o, .irq_o
    );
    sli_term_model term_u
    (
        .prog_en_i(prog_en_o), .baud_div_i(prog_baud_div_o), .data_bits_i(prog_data_bits_o),
        .stop_bits_i(prog_stop_bits_o), .parity_en_i(prog_parity_en_o), .echo_i(prog_echo_o),
        .xonxoff_i(prog_xonxoff_o), .link_ok_o(link_ok)
    );
    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i   <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    // pulse inputs for a single sampled cycle, then wait n edges
    // mask bits: 0 port one overrun, 1 port two overrun, 2 prog button, 3 reset button
    task automatic pulse(input logic [3:0] m, input int n);
        @(posedge clk_i);
        {reset_btn_i, prog_btn_i, ovr2_i, ovr1_i} <= m;
        @(posedge clk_i);
        {reset_btn_i, prog_btn_i, ovr2_i, ovr1_i} <= 4'h0;
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic lamps(input string name, input logic [3:0] e);
        @(negedge clk_i);
        chk(name, {28'h0, led_fault_o, led_status_o, led_err1_o, led_err2_o}, {28'h0, e});
    endtask
    // one full group is n blinks of two halves plus the pause
    task automatic blinks(input logic [15:0] code, input int n);
        int k;
        int seen;
        logic prev;
        wr(SLI_CTRL_OFS, 32'h2);
        wr(SLI_CODE_OFS, {16'h0, code});
        wr(SLI_CTRL_OFS, 32'h1);
        k = 0;
        while (led_status_o !== 1'b1 && k < 100)
        begin
            @(negedge clk_i);
            k++;
        end
        if (k == 100)
        begin
            bad_count++;
            end_of_test();
        end
        seen = 1;
        prev = 1'b1;
        repeat (n * 2 * HALF + PAUSE - 1)
        begin
            @(negedge clk_i);
            if (led_status_o && !prev)
                seen++;
            prev = led_status_o;
        end
        chk("blink count", 32'(seen), 32'(n));
        chk("kernel port lamps", {30'h0, led_err1_o, led_err2_o}, 32'h0);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        int k;
        rstn_i = 1'b0;
        reset_btn_i = 1'b0;
        prog_btn_i = 1'b0;
        ovr1_i = 1'b0;
        ovr2_i = 1'b0;
        we_i = 1'b0;
        re_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        lamps("reset lamps", 4'h0);
        chk("no programming yet", {31'h0, link_ok}, 32'h0);
        pulse(4'h1, 1);
        lamps("port one overrun", 4'b0010);
        pulse(4'h2, 1);
        lamps("port two overrun", 4'b0011);
        repeat (20) @(posedge clk_i);
        lamps("error lamps held", 4'b0011);
        rd(SLI_STATE_OFS, v);
        chk("state flags", v & 32'hf, 32'hc);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        wr(SLI_IRQ_MASK_OFS, 32'h2);
        repeat (2) @(negedge clk_i);
        chk("irq raised", {31'h0, irq_o}, 32'h1);
        wr(SLI_IRQ_STAT_OFS, 32'h6);
        @(negedge clk_i);
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        rd(8'h20, v);
        chk("unmapped read", v, 32'h0);
        pulse(4'h4, 1);
        lamps("programming lamps", 4'b0100);
        chk("terminal link", {31'h0, link_ok}, 32'h1);
        rd(SLI_IRQ_STAT_OFS, v);
        chk("programming event", v, 32'h1);
        for (int i = 0; i < 11; i++)
            blinks(codes[i], nblk[i]);
        wr(SLI_CODE_OFS, 32'h0);
        pulse(4'h1, 3);
        k = 0;
        repeat (30)
        begin
            @(negedge clk_i);
            k += int'(led_status_o === 1'b1);
        end
        chk("steady lamp", 32'(k), 32'd30);
        chk("kernel port lamps", {30'h0, led_err1_o, led_err2_o}, 32'h0);
        wr(SLI_CTRL_OFS, 32'h5);
        @(negedge clk_i);
        lamps("kernel fault lamp", 4'b1100);
        rd(SLI_CTRL_OFS, v);
        chk("fault bit readback", v, 32'h4);
        pulse(4'h8, 0);
        lamps("button reset", 4'h0);
        rd(SLI_STATE_OFS, v);
        chk("mode after button reset", v & 32'h3, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
